// File: hdl/rst_pd_ctrl.sv
// Reset sequencing and automatic power-down for the memory/logic module
`timescale 1ns/1ps
`default_nettype none
`include "rst_pd_map.svh"
module rst_pd_ctrl
   import rst_pd_pkg::*;
#(
   parameter int PO_CYC = (`PO_PULSE_NS + `CLK_NS - 1) / `CLK_NS,
   parameter int WARM_CYC = (`WARM_PULSE_NS + `CLK_NS - 1) / `CLK_NS,
   parameter int OPR_CYC = (`OPR_DELAY_NS + `CLK_NS - 1) / `CLK_NS,
   parameter int IDLE_CYC = `IDLE_CLOCKS,
   parameter logic [7:0] MAP_CFG = 8'hFF
) (
   input wire logic clk_i, // 50 MHz
   input wire logic rst_i, // Async power-up reset
   input wire logic reset_n_i, // Core reset pin, low active
   input wire logic ale_i, // Address-latch strobe
   input wire logic lockout_i, // Supply below lockout threshold
   input wire logic flash_wr_req_i, // Flash write cycle request
   input wire logic [3:0] logic_in_i, // Logic array inputs
   input wire logic [3:0] addr_in_i, // Address inputs to array
   input wire logic awvalid, // AXI write address valid
   output logic awready, // AXI write address ready
   input wire logic [31:0] awaddr, // AXI write address
   input wire logic wvalid, // AXI write data valid
   output logic wready, // AXI write data ready
   input wire logic [31:0] wdata, // AXI write data
   input wire logic [3:0] wstrb, // AXI byte strobes
   output logic bvalid, // AXI write response valid
   input wire logic bready, // AXI response ready
   output logic [1:0] bresp, // AXI write response
   input wire logic arvalid, // AXI read address valid
   output logic arready, // AXI read address ready
   input wire logic [31:0] araddr, // AXI read address
   output logic rvalid, // AXI read data valid
   input wire logic rready, // AXI read ready
   output logic [31:0] rdata, // AXI read data
   output logic [1:0] rresp, // AXI read response
   output logic powerdown_request_o, // Power-down active
   output logic ready_o, // Module operational
   output logic flash_read_mode_o, // Flash in read mode
   output logic flash_wr_start_o, // Flash write cycle started
   output pin_mode_t pin_mode_o, // Pin states
   output logic [3:0] logic_out_o, // Logic array outputs
   output logic [3:0] macro_ff_o, // Macrocell flip-flops
   output logic irq_o // Interrupt level
);
   // Counters are 16 and 8 bits wide; refuse timings they cannot hold
   if (PO_CYC < 1 || WARM_CYC < 1 || OPR_CYC < 1 || PO_CYC > 65535 || WARM_CYC > 65535
      || OPR_CYC > 65535 || IDLE_CYC < 1 || IDLE_CYC > 255) begin : g_bad_timing
      $error("bad timing parameter");
   end

   seq_state_t state_ff;
   logic [15:0] cnt_ff;
   logic [2:0] rsync_ff, async_ff;
   logic [7:0] idle_ff;
   logic cold_ff;
   logic [7:0] pmr_a_ff, pmr_b_ff, map_ff, scratch_ff;
   logic [2:0] irq_stat_ff, irq_mask_ff;
   logic aw_ff, w_ff;
   logic [31:0] awaddr_ff, wdata_ff;
   logic [3:0] wstrb_ff;
   logic in_reset, rst_seen, rst_rel, ale_edge, ale_lvl, ale_lvl_q, do_write;
   logic [2:0] ev;

   // Three-stage sync; second and third must agree
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rsync_ff <= 3'b000;
         async_ff <= 3'b000;
      end else begin
         rsync_ff <= {rsync_ff[1:0], ~reset_n_i};
         async_ff <= {async_ff[1:0], ale_i};
      end
   end
   assign rst_seen = rsync_ff[1] & rsync_ff[2];
   assign rst_rel = ~rsync_ff[1] & ~rsync_ff[2];
   assign ale_lvl = async_ff[2];
   // Disagreement means the strobe is moving; a settled change counts as well
   assign ale_edge = (async_ff[1] != ale_lvl) || (ale_lvl != ale_lvl_q);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) ale_lvl_q <= 1'b0;
      else if (async_ff[1] == async_ff[2]) ale_lvl_q <= async_ff[2];
   end

   // Reset sequencer: minimum pulse, then operational delay
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= ST_COLD;
         cnt_ff <= 16'h0000;
         cold_ff <= 1'b1;
      end else begin
         unique case (state_ff)
            ST_COLD, ST_HOLD: begin
               if (rst_seen) begin
                  if (cnt_ff != 16'hFFFF) cnt_ff <= cnt_ff + 16'h0001;
               end else if (rst_rel && cnt_ff >= 16'(cold_ff ? PO_CYC : WARM_CYC)) begin
                  state_ff <= ST_DELAY;
                  cnt_ff <= 16'h0000;
               end
            end
            ST_DELAY: begin
               if (rst_seen) begin
                  state_ff <= ST_HOLD;
                  cnt_ff <= 16'h0000;
               end else if (cnt_ff == 16'(OPR_CYC - 1)) begin
                  state_ff <= ST_RUN;
                  cold_ff <= 1'b0;
               end else begin
                  cnt_ff <= cnt_ff + 16'h0001;
               end
            end
            ST_RUN: begin
               if (rst_seen) begin
                  state_ff <= ST_HOLD;
                  cnt_ff <= 16'h0001;
               end
            end
         endcase
      end
   end
   assign in_reset = (state_ff != ST_RUN);

   // Idle counter on static address strobe
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         idle_ff <= 8'h00;
         powerdown_request_o <= 1'b0;
      end else if (!pmr_a_ff[`BIT_APD_EN] || ale_edge || in_reset) begin
         idle_ff <= 8'h00;
         powerdown_request_o <= 1'b0;
      end else if (idle_ff < 8'(IDLE_CYC)) begin
         idle_ff <= idle_ff + 8'h01;
         powerdown_request_o <= (idle_ff == 8'(IDLE_CYC - 1));
      end
   end

   // Status outputs, pins and flash write gating
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ready_o <= 1'b0;
         flash_read_mode_o <= 1'b1;
         flash_wr_start_o <= 1'b0;
         pin_mode_o <= '{1'b1, 1'b1, 1'b1, 1'b0};
      end else begin
         ready_o <= (state_ff == ST_RUN);
         flash_read_mode_o <= in_reset | ~flash_wr_req_i;
         flash_wr_start_o <= flash_wr_req_i & ~lockout_i & ~in_reset;
         pin_mode_o.mcu_io_input <= in_reset;
         pin_mode_o.addr_out_float <= in_reset;
         pin_mode_o.periph_float <= in_reset | powerdown_request_o;
         pin_mode_o.array_addr_block <= powerdown_request_o;
      end
   end

   // Logic array: live through reset, addresses blocked from logic_out_o in power-down
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         logic_out_o <= 4'h0;
         macro_ff_o <= 4'h0;
      end else begin
         logic_out_o <= logic_in_i ^ (powerdown_request_o ? 4'h0 : addr_in_i);
         macro_ff_o <= (macro_ff_o & ~logic_in_i) | (logic_in_i & addr_in_i);
      end
   end

   // AXI write capture, either order
   assign do_write = aw_ff && w_ff && !bvalid;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         awaddr_ff <= 32'h0000_0000;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         bvalid <= 1'b0;
         bresp <= 2'b00;
      end else begin
         if (awvalid && awready) begin
            aw_ff <= 1'b1;
            awaddr_ff <= awaddr;
         end
         if (wvalid && wready) begin
            w_ff <= 1'b1;
            wdata_ff <= wdata;
            wstrb_ff <= wstrb;
         end
         if (do_write) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            bvalid <= 1'b1;
            bresp <= known(awaddr_ff) ? 2'b00 : 2'b10;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end
   assign awready = !aw_ff && !bvalid;
   assign wready = !w_ff && !bvalid;

   function automatic logic known(input logic [31:0] a);
      known = a == `OFF_PMR_A || a == `OFF_PMR_B || a == `OFF_MAP_MODE || a == `OFF_IRQ_STAT
         || a == `OFF_IRQ_MASK || a == `OFF_STATUS || a == `OFF_SCRATCH;
   endfunction

   // Power registers clear only at power-up
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pmr_a_ff <= `RST_ZERO;
         pmr_b_ff <= `RST_ZERO;
      end else if (do_write && wstrb_ff[0]) begin
         if (awaddr_ff == `OFF_PMR_A) pmr_a_ff <= wdata_ff[7:0];
         if (awaddr_ff == `OFF_PMR_B) pmr_b_ff <= wdata_ff[7:0];
      end
   end

   // Map, scratch and IRQ mask reset on either reset (map loads MAP_CFG with both mapping bits cleared), kept in power-down
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         map_ff <= `RST_ZERO;
         scratch_ff <= `RST_ZERO;
         irq_mask_ff <= 3'b000;
      end else if (in_reset) begin
         map_ff <= MAP_CFG & ~(8'h01 << `BIT_CODE_MAP) & ~(8'h01 << `BIT_PERIPH_MODE);
         scratch_ff <= `RST_ZERO;
         irq_mask_ff <= 3'b000;
      end else if (do_write && wstrb_ff[0]) begin
         if (awaddr_ff == `OFF_MAP_MODE) map_ff <= wdata_ff[7:0];
         if (awaddr_ff == `OFF_SCRATCH) scratch_ff <= wdata_ff[7:0];
         if (awaddr_ff == `OFF_IRQ_MASK) irq_mask_ff <= wdata_ff[2:0];
      end
   end

   // Sticky events: power-down entry, ready, lockout refusal; set beats clear
   assign ev = {flash_wr_req_i & lockout_i & ~in_reset, (state_ff == ST_DELAY) && (cnt_ff == 16'(OPR_CYC - 1)),
      powerdown_request_o == 1'b0 && idle_ff == 8'(IDLE_CYC - 1) && pmr_a_ff[`BIT_APD_EN] && !ale_edge && !in_reset};
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_stat_ff <= 3'b000;
         irq_o <= 1'b0;
      end else begin
         irq_stat_ff <= (irq_stat_ff & ~((do_write && awaddr_ff == `OFF_IRQ_STAT && wstrb_ff[0])
            ? wdata_ff[2:0] : 3'b000)) | ev;
         irq_o <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   // AXI read
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= 2'b00;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp <= known(araddr) ? 2'b00 : 2'b10;
         unique case (araddr)
            `OFF_PMR_A: rdata <= {24'h00_0000, pmr_a_ff};
            `OFF_PMR_B: rdata <= {24'h00_0000, pmr_b_ff};
            `OFF_MAP_MODE: rdata <= {24'h00_0000, map_ff};
            `OFF_IRQ_STAT: rdata <= {29'h0000_0000, irq_stat_ff};
            `OFF_IRQ_MASK: rdata <= {29'h0000_0000, irq_mask_ff};
            `OFF_STATUS: rdata <= {28'h000_0000, cold_ff, in_reset, ready_o, powerdown_request_o};
            `OFF_SCRATCH: rdata <= {24'h00_0000, scratch_ff};
            default: rdata <= 32'h0000_0000;
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end
   assign arready = !rvalid;

   idle_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(powerdown_request_o) |-> $past(idle_ff) == 8'(IDLE_CYC - 1))
      else $error("power-down not after idle count");
   apd_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !pmr_a_ff[`BIT_APD_EN] |=> !powerdown_request_o)
      else $error("power-down while disabled");
   ready_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(ready_o) |-> $past(state_ff, 2) == ST_DELAY)
      else $error("ready without delay");
   warm_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_ff == ST_RUN && rst_seen) |=> ##1 !ready_o)
      else $error("warm reset ignored");
   lockout_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(lockout_i) |-> !flash_wr_start_o)
      else $error("write started under lockout");
   map_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(in_reset) |-> map_ff[`BIT_CODE_MAP] == 1'b0 && map_ff[`BIT_PERIPH_MODE] == 1'b0)
      else $error("mapping bits not forced");
   pins_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(in_reset) |-> pin_mode_o.mcu_io_input && pin_mode_o.periph_float)
      else $error("pins not safe in reset");
   pmr_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (in_reset && !do_write) |=> $stable(pmr_a_ff))
      else $error("power register changed by reset");
   addr_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
      powerdown_request_o |=> logic_out_o == $past(logic_in_i))
      else $error("address leaked in power-down");
endmodule // rst_pd_ctrl
`default_nettype wire

// File: pkg/rst_pd_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RST_PD_MAP_SVH
`define RST_PD_MAP_SVH
`define OFF_PMR_A 32'h0000_00B0
`define OFF_PMR_B 32'h0000_00B4
`define OFF_MAP_MODE 32'h0000_00B8
`define OFF_IRQ_STAT 32'h0000_00C0
`define OFF_IRQ_MASK 32'h0000_00C4
`define OFF_STATUS 32'h0000_00C8
`define OFF_SCRATCH 32'h0000_00CC
`define BIT_APD_EN 1
`define BIT_CODE_MAP 0
`define BIT_PERIPH_MODE 1
`define IDLE_CLOCKS 15
`define PO_PULSE_NS 1000
`define WARM_PULSE_NS 100
`define OPR_DELAY_NS 200
`define CLK_NS 20
`define RST_ZERO 8'h00
`endif

// File: pkg/rst_pd_pkg.sv
// Types shared by the reset and power-down controller
package rst_pd_pkg;
   typedef enum logic [1:0] {
      ST_COLD = 2'b00,
      ST_HOLD = 2'b01,
      ST_DELAY = 2'b10,
      ST_RUN = 2'b11
   } seq_state_t;
   typedef struct packed {
      logic mcu_io_input;
      logic addr_out_float;
      logic periph_float;
      logic array_addr_block;
   } pin_mode_t;
endpackage

// File: tb/core_model.sv
// Core-side partner: reset pin, address strobe and flash write request
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input wire logic clk_i, // Bench clock
   input wire logic pulse_ale_i, // Keep the strobe toggling
   input wire logic want_wr_i, // Bench wants a flash write
   output logic reset_n_o, // Reset pin, low active
   output logic ale_o, // Address-latch strobe
   output logic wr_req_o // Flash write request
);
   // Reset pin is low from power-up until the first pulse ends
   initial begin
      reset_n_o = 1'b0;
      ale_o = 1'b0;
      wr_req_o = 1'b0;
   end
   // Hold the pin low for n clocks; callers pass at least the pulse width
   task automatic do_reset(input int n);
      @(posedge clk_i);
      reset_n_o <= 1'b0;
      repeat (n) @(posedge clk_i);
      reset_n_o <= 1'b1;
   endtask
   // Strobe toggles each clock while the core is busy, else it stands still
   always @(posedge clk_i) begin
      if (pulse_ale_i) ale_o <= ~ale_o;
   end
   // No request while reset is held, so no stray first write edge
   always @(posedge clk_i) begin
      wr_req_o <= want_wr_i & reset_n_o;
   end
endmodule // core_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the reset sequencer and idle power-down
`timescale 1ns/1ps
`default_nettype none
`include "rst_pd_map.svh"
module testbench;
   localparam int PO = 50, WARM = 5, OPR = 10, IDLE = 15;
   logic clk_i, rst_i, lockout_i, pulse_ale, want_wr, reset_n, ale, wr_req;
   logic [3:0] logic_in, addr_in, wstrb, macro_ff, logic_out, pins;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [1:0] bresp, rresp;
   logic pd, ready, rd_mode, wr_start, irq;
   int error_cnt, check_count, n;
   int mdl[int];
   rst_pd_ctrl #(.PO_CYC(PO), .WARM_CYC(WARM), .OPR_CYC(OPR), .IDLE_CYC(IDLE)) i_rst_pd_ctrl (
      .clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n), .ale_i(ale), .lockout_i(lockout_i),
      .flash_wr_req_i(wr_req), .logic_in_i(logic_in), .addr_in_i(addr_in),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .powerdown_request_o(pd), .ready_o(ready),
      .flash_read_mode_o(rd_mode), .flash_wr_start_o(wr_start), .pin_mode_o(pins),
      .logic_out_o(logic_out), .macro_ff_o(macro_ff), .irq_o(irq));
   core_model i_core_model (.clk_i(clk_i), .pulse_ale_i(pulse_ale), .want_wr_i(want_wr),
      .reset_n_o(reset_n), .ale_o(ale), .wr_req_o(wr_req));
   // Clock, 20 ns period
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // Watchdog, far beyond the few hundred clocks the run needs
   initial begin
      #(20 * 20000);
      error_cnt++;
      wrap_up();
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // One write; the model keeps lane 0 only, status bits are set by hand
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk(bresp, mdl.exists(a) ? 2'b00 : 2'b10);
      if (mdl.exists(a) && a != `OFF_IRQ_STAT) mdl[a] = d & 32'h0000_00FF;
   endtask
   // One read compared with the model under a bit mask
   task automatic rd(input logic [31:0] a, input logic [31:0] m);
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_i);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk(rresp, mdl.exists(a) ? 2'b00 : 2'b10);
      chk(rdata & m, mdl.exists(a) ? mdl[a] & m : 32'h0);
   endtask
   // Read every word from B0 to CC except C0 and C8; BC is a hole
   task automatic rd_all();
      for (int a = 'hB0; a <= 'hCC; a += 4) begin
         if (a != `OFF_IRQ_STAT && a != `OFF_STATUS) rd(a, 32'hFFFF_FFFF);
      end
   endtask
   // Count clocks from reset release until ready
   task automatic wait_ready();
      n = 0;
      while (ready !== 1'b1 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      chk(n >= OPR && n <= OPR + 10, 1'b1);
   endtask
   initial begin
      rst_i = 1'b1;
      lockout_i = 1'b0;
      pulse_ale = 1'b1;
      want_wr = 1'b0;
      logic_in = 4'h0;
      addr_in = 4'h0;
      wstrb = 4'hF;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, wdata, araddr} = '0;
      for (int a = 'hB0; a <= 'hCC; a += 4) mdl[a] = 0;
      mdl.delete('hBC);
      mdl[`OFF_MAP_MODE] = 'hFC;
      void'($urandom(32'h9620942a));
      repeat (12) @(posedge clk_i);
      chk({pins, rd_mode, ready, macro_ff}, {4'b1110, 1'b1, 1'b0, 4'h0});
      rst_i <= 1'b0;
      // Cold start: long pulse, then the hold-off before any access
      i_core_model.do_reset(PO + 6);
      wait_ready();
      chk({rd_mode, macro_ff}, {1'b1, 4'h0});
      mdl[`OFF_STATUS] = 2;
      rd(`OFF_STATUS, 32'hF);
      rd_all();
      $display("cold reset test done");
      wr(`OFF_PMR_A, 32'h0000_0002);
      wr(`OFF_PMR_B, $urandom);
      wr(`OFF_SCRATCH, $urandom);
      wr(32'h0000_0010, 32'h0000_00FF);
      rd_all();
      $display("register test done");
      // Warm pulse of random length; pins and logic outputs checked in reset
      logic_in <= 4'($urandom);
      addr_in <= 4'($urandom);
      i_core_model.do_reset(WARM + 4 + int'($urandom % 4));
      chk({pins[3:1], ready}, {3'b111, 1'b0});
      chk(logic_out, logic_in ^ addr_in);
      chk(macro_ff, logic_in & addr_in);
      wait_ready();
      mdl[`OFF_MAP_MODE] = 'hFC;
      mdl[`OFF_IRQ_MASK] = 0;
      mdl[`OFF_SCRATCH] = 0;
      rd_all();
      $display("warm reset test done");
      // Pulsing strobe holds the counter off; a still one trips it
      repeat (40) @(posedge clk_i);
      chk(pd, 1'b0);
      pulse_ale <= 1'b0;
      n = 0;
      while (pd !== 1'b1 && n < 60) begin
         @(posedge clk_i);
         n++;
      end
      chk(n >= IDLE && n <= IDLE + 7, 1'b1);
      logic_in <= 4'($urandom);
      addr_in <= 4'($urandom);
      repeat (3) @(posedge clk_i);
      chk({pins[1:0], logic_out}, {2'b11, logic_in});
      // Entry event: masked, then unmasked, then cleared
      mdl[`OFF_IRQ_STAT] = 1;
      rd(`OFF_IRQ_STAT, 32'h1);
      chk(irq, 1'b0);
      wr(`OFF_IRQ_MASK, 32'h1);
      repeat (3) @(posedge clk_i);
      chk(irq, 1'b1);
      wr(`OFF_IRQ_STAT, 32'h1);
      mdl[`OFF_IRQ_STAT] = 0;
      repeat (3) @(posedge clk_i);
      chk(irq, 1'b0);
      rd(`OFF_IRQ_STAT, 32'h1);
      rd(`OFF_PMR_A, 32'hFF);
      pulse_ale <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk(pd, 1'b0);
      wr(`OFF_PMR_A, 32'h0);
      pulse_ale <= 1'b0;
      repeat (40) @(posedge clk_i);
      chk(pd, 1'b0);
      pulse_ale <= 1'b1;
      $display("power-down test done");
      // Write request refused below the lockout threshold
      lockout_i <= 1'b1;
      want_wr <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk(wr_start, 1'b0);
      mdl[`OFF_IRQ_STAT] = 4;
      rd(`OFF_IRQ_STAT, 32'h4);
      lockout_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk(wr_start, 1'b1);
      want_wr <= 1'b0;
      $display("lockout test done");
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
